/* File: ctm_pkg.sv */
// Package for the compact timer: register map, fields, modes, reset values.
// Assumes a 32-bit Avalon-MM slave with word-aligned registers.
package ctm_pkg;

  localparam int CNT_W = 10;
  localparam int RP_W  = 3;

  // Byte addresses of the registers
  localparam logic [3:0] ADDR_CTRL0   = 4'h0;
  localparam logic [3:0] ADDR_MODECTL = 4'h4;
  localparam logic [3:0] ADDR_CMPA    = 4'h8;
  localparam logic [3:0] ADDR_COUNT   = 4'hC;

  // Control register 0 fields
  localparam int C0_RUN_ON   = 3;
  localparam int C0_PERIOD_L = 0;
  localparam int C0_TICK     = 4;
  localparam int C0_AFLAG    = 8;
  localparam int C0_PFLAG    = 9;

  // Mode/output control fields
  localparam int MC_MODE_L   = 6;
  localparam int MC_PIN_L    = 4;
  localparam int MC_LEVEL    = 3;
  localparam int MC_INVERT   = 2;
  localparam int MC_SWAP     = 1;
  localparam int MC_CLRSEL   = 0;

  localparam logic [7:0]       MODECTL_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CMPA_RESET    = 10'h000;
  localparam logic [RP_W-1:0]  PERIOD_RESET  = 3'h0;
  localparam logic [CNT_W-1:0] COUNT_MAX     = 10'h3FF;
  localparam logic [CNT_W-1:0] COUNT_ZERO    = 10'h000;

  typedef enum logic [1:0] {
    MODE_COMPARE = 2'h0,
    MODE_UNDEF   = 2'h1,
    MODE_PWM     = 2'h2,
    MODE_TIMER   = 2'h3
  } op_mode_t;

  typedef enum logic [1:0] {
    PIN_KEEP   = 2'h0,
    PIN_LOW    = 2'h1,
    PIN_HIGH   = 2'h2,
    PIN_TOGGLE = 2'h3
  } pin_action_t;

  // Period compare code to 11-bit period; code 0 means full 1024
  function automatic logic [CNT_W:0] period_ticks(input logic [RP_W-1:0] code);
    period_ticks = (code == 3'h0) ? 11'h400 : {1'b0, code, 7'h00};
  endfunction

endpackage

/* File: ctm_pin_action.sv */
// Compare-mode pin action decoder.
// Assumes caller applies it only on a comparator A flag.
`timescale 1ns/10ps
module ctm_pin_action (
  input  wire logic                 curLevel,
  input  wire ctm_pkg::pin_action_t action,
  output logic                      nextLevel
);
  import ctm_pkg::*;

  always_comb begin
    unique case (action)
      PIN_KEEP:   nextLevel = curLevel;   // R4
      PIN_LOW:    nextLevel = 1'b0;
      PIN_HIGH:   nextLevel = 1'b1;
      PIN_TOGGLE: nextLevel = ~curLevel;
    endcase
  end
endmodule

/* File: ctm_pwm_level.sv */
// PWM raw level: active while count below duty, 100% when duty reaches period.
// Assumes duty and period already chosen by the swap bit.
`timescale 1ns/10ps
module ctm_pwm_level (
  input  wire logic [10:0] count,
  input  wire logic [10:0] duty,
  input  wire logic [10:0] period,
  output logic             active
);
  assign active = (duty >= period) || (count < duty); // R23 R26
endmodule

/* File: ctm_timer.sv */
// Compact 10-bit timer: mode/output control, counter, comparators, output pin.
// Assumes count tick input pulses once per selected timer clock.
//
// Contract
// R1: Mode 00 compare, 10 PWM, 11 timer
// R2: Software stops timer before changing mode
// R3: Timer mode leaves output pin undriven
// R4: Compare mode pin action on A match
// R5: PWM pin field: inactive, active, waveform
// R6: Same level as initial gives no change
// R7: Run bit rise restores initial pin level
// R8: Change PWM pin field only when stopped
// R9: Level bit: initial or active level
// R10: Invert bit flips pin except timer mode
// R11: Swap bit exchanges period and duty sources
// R12: Clear select: A match, or P/overflow
// R13: Overflow clear only when period code zero
// R14: PWM ignores clear select bit
// R15: Clear-select 0 raises both flags
// R16: Clear-select 1 never raises P flag
// R17: A zero with A-clear: overflow, no flag
// R18: Only A flag events change the pin
// R19: Timer mode counts like compare mode
// R20: PWM raises both flags separately
// R21: Period 128 times code, 000 gives 1024
// R22: Swapped: duty in 128 steps, 000 is 1024
// R23: Duty at or above period gives 100%
// R24: 10-bit up counter, cleared on run rise
// R25: P compares top three bits, A all
// R26: PWM active while count below duty
`timescale 1ns/10ps
module ctm_timer (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        countTick,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             timerOutputPin,
  output logic             timerOutputPinOe,
  output logic             compareAFlag,
  output logic             comparePFlag
);
  import ctm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]       modeCtl_r;
  logic [RP_W-1:0]  periodCmp_r;
  logic             runOn_r;
  logic             runOnDly_r;
  logic [CNT_W-1:0] compareA_r;
  logic [CNT_W-1:0] count_r;
  logic             aFlag_r;
  logic             pFlag_r;
  logic             level_r;
  logic             ack_r;
  logic             waitReq_r;
  logic [31:0]      rdata_r;
  logic             pin_r;
  logic             pinOe_r;

  op_mode_t    mode;
  pin_action_t pinAct;
  logic        initLevel;
  logic        invert;
  logic        swapDp;
  logic        clrSel;
  assign mode      = op_mode_t'(modeCtl_r[MC_MODE_L+1:MC_MODE_L]);
  assign pinAct    = pin_action_t'(modeCtl_r[MC_PIN_L+1:MC_PIN_L]);
  assign initLevel = modeCtl_r[MC_LEVEL];
  assign invert    = modeCtl_r[MC_INVERT];
  assign swapDp    = modeCtl_r[MC_SWAP];
  assign clrSel    = modeCtl_r[MC_CLRSEL];

  ////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, answer when ack_r is high
  logic req;
  logic wrTake;
  logic clrA;
  logic clrP;
  assign req    = avs_read | avs_write;
  assign wrTake = avs_write & ack_r;
  assign clrA   = wrTake && avs_address == ADDR_CTRL0 && avs_byteenable[1]
                  && !avs_writedata[C0_AFLAG];
  assign clrP   = wrTake && avs_address == ADDR_CTRL0 && avs_byteenable[1]
                  && !avs_writedata[C0_PFLAG];

  // Wait flag kept in its own flop so the port comes straight from a register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_r     <= 1'b0;
      waitReq_r <= 1'b1;
    end else begin
      ack_r     <= req & ~ack_r;
      waitReq_r <= ~(req & ~ack_r);
    end
  end
  assign avs_waitrequest = waitReq_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      modeCtl_r   <= MODECTL_RESET;
      periodCmp_r <= PERIOD_RESET;
      runOn_r     <= 1'b0;
      compareA_r  <= CMPA_RESET;
    end else if (wrTake) begin
      unique case (avs_address)
        ADDR_CTRL0: begin
          if (avs_byteenable[0]) begin
            runOn_r     <= avs_writedata[C0_RUN_ON];
            periodCmp_r <= avs_writedata[C0_PERIOD_L+RP_W-1:C0_PERIOD_L];
          end
        end
        ADDR_MODECTL: begin
          if (avs_byteenable[0]) begin
            modeCtl_r <= avs_writedata[7:0]; // R1
          end
        end
        ADDR_CMPA: begin
          if (avs_byteenable[0]) begin
            compareA_r[7:0] <= avs_writedata[7:0];
          end
          if (avs_byteenable[1]) begin
            compareA_r[9:8] <= avs_writedata[9:8];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read & ~ack_r) begin
      unique case (avs_address)
        ADDR_CTRL0:   rdata_r <= {22'h0, pFlag_r, aFlag_r, 4'h0, runOn_r, periodCmp_r};
        ADDR_MODECTL: rdata_r <= {24'h0, modeCtl_r};
        ADDR_CMPA:    rdata_r <= {22'h0, compareA_r};
        ADDR_COUNT:   rdata_r <= {22'h0, count_r};
        default:      rdata_r <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // Counter and comparators
  logic runRise;
  logic advance;
  logic matchA;
  logic matchP;
  logic atMax;
  logic pwmMode;
  logic clearOnA;
  logic counterClr;
  logic raiseA;
  logic raiseP;

  assign runRise = runOn_r & ~runOnDly_r;
  assign advance = runOn_r & countTick & ~runRise;
  assign pwmMode = (mode == MODE_PWM);
  assign atMax   = (count_r == COUNT_MAX);
  assign matchA  = advance && (compareA_r != COUNT_ZERO)
                   && (count_r + 10'h001 == compareA_r);       // R25
  assign matchP  = advance && (periodCmp_r != PERIOD_RESET)
                   && (count_r[9:7] + 3'h1 == periodCmp_r) && (count_r[6:0] == 7'h7F); // R25

  // PWM: swap decides period source; otherwise clear select
  assign clearOnA   = pwmMode ? swapDp : clrSel;               // R11 R14
  assign counterClr = clearOnA ? matchA
                              : (matchP || (advance && atMax && periodCmp_r == PERIOD_RESET)); // R12 R13 R17
  assign raiseA     = matchA;                                  // R15 R20
  assign raiseP     = matchP && !(clrSel && !pwmMode);         // R16

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      runOnDly_r <= 1'b0;
    end else begin
      runOnDly_r <= runOn_r;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_r <= COUNT_ZERO;
    end else if (runRise) begin
      count_r <= COUNT_ZERO;                                   // R24
    end else if (counterClr || (advance && atMax)) begin
      count_r <= COUNT_ZERO;                                   // R19
    end else if (advance) begin
      count_r <= count_r + 10'h001;
    end
  end

  // Hardware set wins over software clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aFlag_r <= 1'b0;
      pFlag_r <= 1'b0;
    end else begin
      aFlag_r <= raiseA | (aFlag_r & ~clrA);
      pFlag_r <= raiseP | (pFlag_r & ~clrP);
    end
  end
  assign compareAFlag = aFlag_r;
  assign comparePFlag = pFlag_r;

  ////////////////////////////////////////////////////////////////////////
  // Output pin
  logic nextLevel;
  logic pwmActive;
  logic [10:0] periodFull;
  logic [10:0] dutyFull;
  logic [10:0] periodA;
  logic [10:0] pwmPeriod;
  logic [10:0] pwmDuty;
  logic        pwmRaw;
  logic        pinNxt;

  ctm_pin_action u_action (
    .curLevel  (level_r),
    .action    (pinAct),
    .nextLevel (nextLevel)
  );

  assign periodFull = period_ticks(periodCmp_r);                // R21
  assign periodA    = (compareA_r == COUNT_ZERO) ? 11'h400 : {1'b0, compareA_r};
  assign dutyFull   = {1'b0, compareA_r};
  assign pwmPeriod  = swapDp ? periodA : periodFull;            // R11
  assign pwmDuty    = swapDp ? periodFull : dutyFull;           // R22

  ctm_pwm_level u_pwm (
    .count  ({1'b0, count_r}),
    .duty   (pwmDuty),
    .period (pwmPeriod),
    .active (pwmActive)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      level_r <= 1'b0;
    end else if (runRise) begin
      level_r <= initLevel;                                    // R7 R9
    end else if (mode == MODE_COMPARE && raiseA) begin
      level_r <= nextLevel;                                    // R4 R6 R18
    end
  end

  always_comb begin
    unique case (pinAct)
      PIN_KEEP:  pwmRaw = ~initLevel;                          // R5
      PIN_LOW:   pwmRaw = initLevel;
      PIN_HIGH:  pwmRaw = pwmActive ? initLevel : ~initLevel;  // R9 R26
      default:   pwmRaw = ~initLevel;
    endcase
    pinNxt = (pwmMode ? pwmRaw : level_r) ^ invert;            // R10
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_r   <= 1'b0;
      pinOe_r <= 1'b0;
    end else begin
      pin_r   <= pinNxt;
      pinOe_r <= (mode == MODE_COMPARE) || pwmMode;            // R3
    end
  end
  assign timerOutputPin   = pin_r;
  assign timerOutputPinOe = pinOe_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_RUN_CLEARS: assert property (@(posedge mclk) disable iff (rst) // R24
    runRise |=> count_r == COUNT_ZERO) else $error("count not cleared on run");
  AST_INIT_LEVEL: assert property (@(posedge mclk) disable iff (rst) // R7
    runRise |=> level_r == $past(initLevel)) else $error("initial level not set");
  AST_NO_P_CLRSEL: assert property (@(posedge mclk) disable iff (rst) // R16
    (!pwmMode && clrSel && !$past(pFlag_r) && !pFlag_r) |=> !pFlag_r || $past(pwmMode)
    ) else $error("P flag with clear on A");
  AST_TIMER_NO_OE: assert property (@(posedge mclk) disable iff (rst) // R3
    mode == MODE_TIMER |=> !pinOe_r) else $error("pin driven in timer mode");
  AST_A_FLAG: assert property (@(posedge mclk) disable iff (rst) // R15
    raiseA |=> aFlag_r) else $error("A flag missed");
  AST_P_FLAG: assert property (@(posedge mclk) disable iff (rst) // R20
    (matchP && pwmMode) |=> pFlag_r) else $error("P flag missed in PWM");
  AST_PIN_ONLY_A: assert property (@(posedge mclk) disable iff (rst) // R18
    (mode == MODE_COMPARE && !raiseA && !runRise) |=> $stable(level_r))
    else $error("pin changed without A flag");
  AST_INVERT: assert property (@(posedge mclk) disable iff (rst) // R10
    (mode == MODE_COMPARE)
    |=> pin_r == ($past(level_r) ^ $past(invert))) else $error("pin polarity wrong");
  AST_FULL_DUTY: assert property (@(posedge mclk) disable iff (rst) // R23
    (pwmMode && pinAct == PIN_HIGH && pwmDuty >= pwmPeriod)
    |=> pin_r == ($past(initLevel) ^ $past(invert))) else $error("full duty not held");

  ////////////////////////////////////////////////////////////////////////
  // Register, counter, flag and pin checks per mode
  AST_MODE_WRITE: assert property (@(posedge mclk) disable iff (rst) // R1
    (wrTake && avs_address == ADDR_MODECTL && avs_byteenable[0])
    |=> modeCtl_r == $past(avs_writedata[7:0])) else $error("mode register write lost");
  AST_OE_DRIVEN: assert property (@(posedge mclk) disable iff (rst) // R3
    (mode == MODE_COMPARE || pwmMode)
    |=> pinOe_r) else $error("pin not driven in output mode");
  AST_CLR_ON_A: assert property (@(posedge mclk) disable iff (rst) // R12
    (!pwmMode && clrSel && matchA)
    |=> count_r == COUNT_ZERO) else $error("count not cleared on A match");
  AST_A_NO_CLEAR: assert property (@(posedge mclk) disable iff (rst) // R12
    (!pwmMode && !clrSel && matchA && !matchP)
    |=> count_r == $past(count_r) + 10'h001) else $error("A match cleared count");
  AST_CLR_ON_P: assert property (@(posedge mclk) disable iff (rst) // R12
    (!pwmMode && !clrSel && matchP)
    |=> count_r == COUNT_ZERO) else $error("count not cleared on P match");
  AST_OVF_CLEAR: assert property (@(posedge mclk) disable iff (rst) // R13
    (advance && atMax)
    |=> count_r == COUNT_ZERO) else $error("no clear at overflow");
  AST_NO_A_ZERO: assert property (@(posedge mclk) disable iff (rst) // R17
    (compareA_r == COUNT_ZERO && !aFlag_r)
    |=> !aFlag_r) else $error("A flag with zero compare");
  AST_P_IN_CMP: assert property (@(posedge mclk) disable iff (rst) // R15
    (!pwmMode && !clrSel && matchP)
    |=> pFlag_r) else $error("P flag missed in compare mode");
  AST_PWM_PERIOD: assert property (@(posedge mclk) disable iff (rst) // R14
    (pwmMode && !swapDp && matchP)
    |=> count_r == COUNT_ZERO) else $error("PWM period not closed by P");
  AST_SWAP_PERIOD: assert property (@(posedge mclk) disable iff (rst) // R11
    (pwmMode && swapDp && matchA)
    |=> count_r == COUNT_ZERO) else $error("swapped period not closed by A");
  AST_PWM_FORCE_OFF: assert property (@(posedge mclk) disable iff (rst) // R5
    (pwmMode && pinAct == PIN_KEEP)
    |=> pin_r != ($past(initLevel) ^ $past(invert))) else $error("inactive level lost");
  AST_PWM_FORCE_ON: assert property (@(posedge mclk) disable iff (rst) // R5
    (pwmMode && pinAct == PIN_LOW)
    |=> pin_r == ($past(initLevel) ^ $past(invert))) else $error("active level lost");
  AST_PWM_WAVE: assert property (@(posedge mclk) disable iff (rst) // R26
    (pwmMode && pinAct == PIN_HIGH && pwmActive)
    |=> pin_r == ($past(initLevel) ^ $past(invert))) else $error("PWM active part wrong");
  AST_PIN_TOGGLE: assert property (@(posedge mclk) disable iff (rst) // R4
    (mode == MODE_COMPARE && raiseA && pinAct == PIN_TOGGLE)
    |=> level_r != $past(level_r)) else $error("toggle on A match missed");
  COV_CMP_A: cover property (@(posedge mclk) disable iff (rst) raiseA && mode == MODE_COMPARE);
  COV_PWM_P: cover property (@(posedge mclk) disable iff (rst) raiseP && pwmMode);
  COV_OVF:   cover property (@(posedge mclk) disable iff (rst) advance && atMax);
  COV_SWAP:  cover property (@(posedge mclk) disable iff (rst) pwmMode && swapDp && matchA);
  COV_TOGL:  cover property (@(posedge mclk) disable iff (rst) raiseA && pinAct == PIN_TOGGLE);
endmodule

/* File: tb_ctm_timer.sv */
// Self-checking bench for the compact timer: registers, compare, timer and PWM.
// Assumes ctm_pkg layout and an Avalon-MM slave that holds waitrequest until it answers.
`timescale 1ns/10ps
module tb_ctm_timer;
  import ctm_pkg::*;
  logic        mclk;
  logic        rst;
  logic        countTick;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        pin;
  logic        pinOe;
  logic        aFlag;
  logic        pFlag;
  logic [31:0] rdat;
  logic        expPin;
  int          miscompares;
  int          comparisons;

  ctm_timer DUT (.mclk(mclk), .rst(rst), .countTick(countTick), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .timerOutputPin(pin), .timerOutputPinOe(pinOe),
    .compareAFlag(aFlag), .comparePFlag(pFlag));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chkW(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request held until waitrequest is sampled low at a rising edge; no fixed latency
  task automatic access(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      summarize();
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  // Tick held high for n edges, then settle so the registered pin is stable
  task automatic tick(input int n);
    @(posedge mclk);
    countTick <= 1'b1;
    repeat (n) @(posedge mclk);
    countTick <= 1'b0;
    idle(2);
  endtask

  task automatic chkCount(input logic [9:0] exp);
    access(1'b0, ADDR_COUNT, 32'h0);
    chkW("count", {22'h0, exp}, rdat);
  endtask

  function automatic logic [31:0] mc(input op_mode_t m, input logic [1:0] act, input logic oc,
                                     input logic inv, input logic sw, input logic cl);
    mc = {24'h0, m, act, oc, inv, sw, cl};
  endfunction

  // Timer stopped around every mode change; run rise clears counter, CTRL0 writes clear flags
  task automatic cfg(input logic [31:0] m, input logic [9:0] a, input logic [2:0] code);
    access(1'b1, ADDR_CTRL0, {29'h0, code});
    access(1'b1, ADDR_MODECTL, m);
    access(1'b1, ADDR_CMPA, {22'h0, a});
    access(1'b0, ADDR_MODECTL, 32'h0);
    chkW("modectl", m, rdat);
    access(1'b1, ADDR_CTRL0, {28'h0, 1'b1, code});
    idle(3);
  endtask

  initial begin
    #300000;
    miscompares++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    countTick = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    miscompares = 0;
    comparisons = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    access(1'b0, ADDR_MODECTL, 32'h0);
    chkW("modectl reset", {24'h0, MODECTL_RESET}, rdat);
    access(1'b0, ADDR_CMPA, 32'h0);
    chkW("cmpa reset", {22'h0, CMPA_RESET}, rdat);
    access(1'b0, 4'h2, 32'h0);
    chkW("unmapped", 32'h0, rdat);
    // Compare mode, clear on A
    cfg(mc(MODE_COMPARE, PIN_HIGH, 1'b0, 1'b0, 1'b0, 1'b1), 10'h005, 3'h1);
    chk1("oe", 1'b1, pinOe);
    tick(4);
    chkCount(10'h004);
    chk1("aflag", 1'b0, aFlag);
    tick(1);
    chk1("aflag", 1'b1, aFlag);
    chk1("pin", 1'b1, pin);
    chkCount(10'h000);
    // Period code below compare A: P match must still raise nothing
    cfg(mc(MODE_COMPARE, PIN_HIGH, 1'b0, 1'b0, 1'b0, 1'b1), 10'h0C8, 3'h1);
    tick(200);
    chk1("aflag", 1'b1, aFlag);
    chk1("pflag", 1'b0, pFlag);
    chkCount(10'h000);
    // Every pin action from both initial levels
    for (int i = 0; i < 8; i++) begin
      cfg(mc(MODE_COMPARE, i[1:0], i[2], 1'b0, 1'b0, 1'b1), 10'h005, 3'h1);
      chk1("initial", i[2], pin);
      tick(5);
      expPin = (i[1:0] == 2'h0) ? i[2] : (i[1:0] == 2'h1) ? 1'b0 : (i[1:0] == 2'h2) ? 1'b1 : ~i[2];
      chk1("action", expPin, pin);
    end
    cfg(mc(MODE_COMPARE, PIN_TOGGLE, 1'b1, 1'b1, 1'b0, 1'b1), 10'h005, 3'h1);
    chk1("inverted", 1'b0, pin);
    tick(5);
    chk1("inverted", 1'b1, pin);
    // Clear on P: A does not clear, P leaves pin alone
    cfg(mc(MODE_COMPARE, PIN_TOGGLE, 1'b0, 1'b0, 1'b0, 1'b0), 10'h003, 3'h1);
    tick(3);
    chk1("aflag", 1'b1, aFlag);
    chkCount(10'h003);
    tick(125);
    chk1("pflag", 1'b1, pFlag);
    chk1("pin", 1'b1, pin);
    chkCount(10'h000);
    cfg(mc(MODE_TIMER, PIN_TOGGLE, 1'b0, 1'b0, 1'b0, 1'b0), 10'h003, 3'h1);
    chk1("oe", 1'b0, pinOe);
    tick(3);
    chk1("aflag", 1'b1, aFlag);
    // Compare A zero with clear on A runs to full count
    cfg(mc(MODE_COMPARE, PIN_KEEP, 1'b0, 1'b0, 1'b0, 1'b1), 10'h000, 3'h1);
    tick(1023);
    chkCount(COUNT_MAX);
    tick(1);
    chkCount(COUNT_ZERO);
    chk1("aflag", 1'b0, aFlag);
    // PWM, period from code, duty from A
    cfg(mc(MODE_PWM, 2'h2, 1'b1, 1'b0, 1'b0, 1'b1), 10'h020, 3'h1);
    chk1("pwm", 1'b1, pin);
    tick(31);
    chk1("pwm", 1'b1, pin);
    tick(1);
    chk1("pwm", 1'b0, pin);
    tick(96);
    chk1("pwm", 1'b1, pin);
    chk1("aflag", 1'b1, aFlag);
    chk1("pflag", 1'b1, pFlag);
    cfg(mc(MODE_PWM, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0), 10'h0C8, 3'h1);
    tick(127);
    chk1("full", 1'b1, pin);
    // Swapped: period from A, duty from code; active low then inverted
    cfg(mc(MODE_PWM, 2'h2, 1'b0, 1'b1, 1'b1, 1'b0), 10'h100, 3'h1);
    tick(127);
    chk1("swap", 1'b1, pin);
    tick(1);
    chk1("swap", 1'b0, pin);
    tick(128);
    chkCount(10'h000);
    cfg(mc(MODE_UNDEF, PIN_KEEP, 1'b0, 1'b0, 1'b0, 1'b0), 10'h020, 3'h1);
    chk1("oe", 1'b0, pinOe);
    // All four PWM pin codes at count zero; undefined code held at the inactive level
    for (int i = 0; i < 4; i++) begin
      cfg(mc(MODE_PWM, i[1:0], 1'b1, 1'b0, 1'b0, 1'b0), 10'h020, 3'h1);
      chk1("forced", (i == 1 || i == 2), pin);
    end
    summarize();
  end
endmodule
